//--- rtl/pld_stretch.sv
// Purpose: lengthens one activity event
// Assumes: counts fit in CW bits
// Notes: reserved length code falls back to normal
`timescale 1ns/100ps
module pld_stretch #(
  parameter int unsigned CW = 24,
  parameter int unsigned NORM_CYC = pld_pkg::STRETCH_NORMAL_CYC,
  parameter int unsigned MED_CYC = pld_pkg::STRETCH_MEDIUM_CYC,
  parameter int unsigned LONG_CYC = pld_pkg::STRETCH_LONG_CYC
) (
  input wire logic clock,
  input wire logic rst,
  pld_str_if.str s
);

  logic [CW-1:0] cnt_ff;
  logic [CW-1:0] load_val;
  logic stretching;

  assign stretching = s.en | s.force_str;

  always_comb
  begin
    case (s.sel)
      pld_pkg::PLD_LEN_MEDIUM: load_val = CW'(MED_CYC);
      pld_pkg::PLD_LEN_LONG: load_val = CW'(LONG_CYC);
      default: load_val = CW'(NORM_CYC);
    endcase
  end

  // ****************************************************
  // hold counter, reloaded while the event lasts
  // ****************************************************
  always_ff @(posedge clock or posedge rst)
  begin
    if (rst)
      cnt_ff <= '0;
    else if (!stretching)
      cnt_ff <= '0;
    else if (s.evt)
      cnt_ff <= load_val;
    else if (cnt_ff != '0)
      cnt_ff <= cnt_ff - CW'(1);
  end

  assign s.active = s.evt | (stretching && (cnt_ff != '0));

  property p_len_load;
    @(posedge clock) disable iff (rst)
    (s.evt && stretching && s.sel == pld_pkg::PLD_LEN_MEDIUM) |=> cnt_ff == CW'(MED_CYC);
  endproperty
  a_len_load: assert property (p_len_load) else $error("medium stretch not loaded");

  property p_tail;
    @(posedge clock) disable iff (rst)
    ($fell(s.evt) && stretching && $stable(s.en) && $stable(s.force_str)) |-> s.active [*2];
  endproperty
  a_tail: assert property (p_tail) else $error("event not lengthened");

  property p_plain;
    @(posedge clock) disable iff (rst)
    (!s.en && !s.force_str) |-> s.active == s.evt;
  endproperty
  a_plain: assert property (p_plain) else $error("unstretched event shown wrongly");

endmodule : pld_stretch

//--- rtl/pld_top.sv
// Purpose: two status led pins with wiring sense and function select
// Assumes: activity and link inputs synchronous to clock
// Notes: led control reached through a plain register port
`timescale 1ns/100ps
module pld_top #(
  parameter int unsigned CW = 24,
  parameter int unsigned NORM_CYC = pld_pkg::STRETCH_NORMAL_CYC,
  parameter int unsigned MED_CYC = pld_pkg::STRETCH_MEDIUM_CYC,
  parameter int unsigned LONG_CYC = pld_pkg::STRETCH_LONG_CYC,
  parameter int unsigned FAST_HALF_CYC = pld_pkg::BLINK_FAST_HALF_CYC,
  parameter int unsigned SLOW_HALF_CYC = pld_pkg::BLINK_SLOW_HALF_CYC
) (
  input wire logic clock,
  input wire logic rst,
  input wire logic reg_wr,
  input wire logic [15:0] reg_wdata,
  output logic [15:0] reg_rdata,
  output logic duplex_default_bit,
  input wire logic tx_act,
  input wire logic rx_act,
  input wire logic col_act,
  input wire logic link_up,
  input wire logic duplex_full,
  input wire logic led_a_pin_in,
  output logic led_a_pin_out,
  output logic led_a_pin_oe,
  input wire logic led_b_pin_in,
  output logic led_b_pin_out,
  output logic led_b_pin_oe
);

  // ****************************************************
  // functions shared by both leds
  // ****************************************************
  function automatic logic func_event(
    input logic [3:0] code,
    input logic tx,
    input logic rx,
    input logic col
  );
    logic e;
    e = 1'b0;
    case (code)
      pld_pkg::PLD_F_TX: e = tx;
      pld_pkg::PLD_F_RX: e = rx;
      pld_pkg::PLD_F_COL: e = col;
      pld_pkg::PLD_F_TXRX: e = tx | rx;
      pld_pkg::PLD_F_LINK_RX: e = rx;
      pld_pkg::PLD_F_LINK_TXRX: e = tx | rx;
      pld_pkg::PLD_F_DUP_COL: e = col;
      default: e = 1'b0;
    endcase
    return e;
  endfunction : func_event

  function automatic logic func_forced(input logic [3:0] code);
    logic f;
    f = 1'b0;
    case (code)
      pld_pkg::PLD_F_LINK_RX,
      pld_pkg::PLD_F_LINK_TXRX,
      pld_pkg::PLD_F_DUP_COL: f = 1'b1;
      default: f = 1'b0;
    endcase
    return f;
  endfunction : func_forced

  // activity inverts the steady level in combined modes so it stays visible
  function automatic logic func_level(
    input logic [3:0] code,
    input logic link,
    input logic dup,
    input logic act,
    input logic fast,
    input logic slow
  );
    logic l;
    l = 1'b0;
    case (code)
      pld_pkg::PLD_F_ON: l = 1'b1;
      pld_pkg::PLD_F_OFF: l = 1'b0;
      pld_pkg::PLD_F_FAST: l = fast;
      pld_pkg::PLD_F_SLOW: l = slow;
      pld_pkg::PLD_F_TX,
      pld_pkg::PLD_F_RX,
      pld_pkg::PLD_F_COL,
      pld_pkg::PLD_F_TXRX: l = act;
      pld_pkg::PLD_F_LINK: l = link;
      pld_pkg::PLD_F_DUP: l = dup;
      pld_pkg::PLD_F_LINK_RX,
      pld_pkg::PLD_F_LINK_TXRX: l = link ^ act;
      pld_pkg::PLD_F_DUP_COL: l = dup ^ act;
      default: l = 1'b0;
    endcase
    return l;
  endfunction : func_level

  // ****************************************************
  // led control register
  // ****************************************************
  logic [15:0] led_control_ff;

  // only the management port reaches this register
  always_ff @(posedge clock or posedge rst)
  begin
    if (rst)
      led_control_ff <= pld_pkg::LED_CONTROL_RST;
    else if (reg_wr)
      led_control_ff <= reg_wdata;
  end

  assign reg_rdata = led_control_ff;

  logic [3:0] code [2];
  logic stretch_en;
  pld_pkg::pld_len_t len_sel;

  assign code[0] = led_control_ff[pld_pkg::LED_A_LSB +: 4];
  assign code[1] = led_control_ff[pld_pkg::LED_B_LSB +: 4];
  assign stretch_en = led_control_ff[pld_pkg::STRETCH_EN_BIT];
  assign len_sel = pld_pkg::pld_len_t'(led_control_ff[pld_pkg::LEN_LSB +: 2]);

  // ****************************************************
  // wiring sense after reset
  // ****************************************************
  pld_pkg::pld_state_t state_ff;
  logic [2:0] sense_cnt_ff;
  logic sink_a_ff;
  logic sink_b_ff;
  logic dup_def_ff;
  logic sense_done;

  assign sense_done = (state_ff == pld_pkg::PLD_SENSE) &&
                      (sense_cnt_ff == pld_pkg::SENSE_CYC - 3'h1);

  // pins float during sense; an led to supply pulls high, one to ground low
  always_ff @(posedge clock or posedge rst)
  begin
    if (rst)
      state_ff <= pld_pkg::PLD_SENSE;
    else
    begin
      case (state_ff)
        pld_pkg::PLD_SENSE: state_ff <= sense_done ? pld_pkg::PLD_RUN : pld_pkg::PLD_SENSE;
        pld_pkg::PLD_RUN: state_ff <= pld_pkg::PLD_RUN;
        default: state_ff <= pld_pkg::PLD_SENSE;
      endcase
    end
  end

  always_ff @(posedge clock or posedge rst)
  begin
    if (rst)
      sense_cnt_ff <= 3'h0;
    else if (state_ff == pld_pkg::PLD_SENSE)
      sense_cnt_ff <= sense_cnt_ff + 3'h1;
  end

  // sampled once at the end of sense, never again until reset
  always_ff @(posedge clock or posedge rst)
  begin
    if (rst)
    begin
      sink_a_ff <= 1'b0;
      sink_b_ff <= 1'b0;
    end
    else if (sense_done)
    begin
      sink_a_ff <= led_a_pin_in;
      sink_b_ff <= led_b_pin_in;
    end
  end

  // a floating pin gives whatever level it drifts to
  always_ff @(posedge clock or posedge rst)
  begin
    if (rst)
      dup_def_ff <= 1'b0;
    else if (sense_done)
      dup_def_ff <= led_b_pin_in;
  end

  assign duplex_default_bit = dup_def_ff;

  // ****************************************************
  // blink dividers
  // ****************************************************
  logic [31:0] fast_cnt_ff;
  logic [31:0] slow_cnt_ff;
  logic fast_ff;
  logic slow_ff;

  always_ff @(posedge clock or posedge rst)
  begin
    if (rst)
    begin
      fast_cnt_ff <= 32'h0;
      fast_ff <= 1'b0;
    end
    else if (fast_cnt_ff == 32'(FAST_HALF_CYC - 1))
    begin
      fast_cnt_ff <= 32'h0;
      fast_ff <= ~fast_ff;
    end
    else
      fast_cnt_ff <= fast_cnt_ff + 32'h1;
  end

  always_ff @(posedge clock or posedge rst)
  begin
    if (rst)
    begin
      slow_cnt_ff <= 32'h0;
      slow_ff <= 1'b0;
    end
    else if (slow_cnt_ff == 32'(SLOW_HALF_CYC - 1))
    begin
      slow_cnt_ff <= 32'h0;
      slow_ff <= ~slow_ff;
    end
    else
      slow_cnt_ff <= slow_cnt_ff + 32'h1;
  end

  // ****************************************************
  // per led decode and stretch
  // ****************************************************
  logic evt [2];
  logic forced [2];
  logic active [2];
  logic lit [2];
  logic sink [2];
  logic pin_out_ff [2];
  logic pin_oe_ff;

  assign sink[0] = sink_a_ff;
  assign sink[1] = sink_b_ff;

  pld_str_if s_if [2] ();

  for (genvar g = 0; g < 2; g++)
  begin : g_led
    assign s_if[g].evt = evt[g];
    assign s_if[g].force_str = forced[g];
    assign s_if[g].en = stretch_en;
    assign s_if[g].sel = len_sel;
    assign active[g] = s_if[g].active;

    pld_stretch #(
      .CW(CW),
      .NORM_CYC(NORM_CYC),
      .MED_CYC(MED_CYC),
      .LONG_CYC(LONG_CYC)
    ) u_stretch (
      .clock(clock),
      .rst(rst),
      .s(s_if[g])
    );
  end

  always_comb
  begin
    for (int i = 0; i < 2; i++)
    begin
      evt[i] = func_event(code[i], tx_act, rx_act, col_act);
      forced[i] = func_forced(code[i]);
      lit[i] = func_level(code[i], link_up, duplex_full, active[i], fast_ff, slow_ff);
    end
  end

  // sinking wiring lights on a low pin, so the drive is inverted
  always_ff @(posedge clock or posedge rst)
  begin
    if (rst)
    begin
      pin_out_ff[0] <= 1'b0;
      pin_out_ff[1] <= 1'b0;
      pin_oe_ff <= 1'b0;
    end
    else
    begin
      pin_oe_ff <= (state_ff == pld_pkg::PLD_RUN);
      for (int i = 0; i < 2; i++)
        pin_out_ff[i] <= (state_ff == pld_pkg::PLD_RUN) ? (lit[i] ^ sink[i]) : 1'b0;
    end
  end

  assign led_a_pin_out = pin_out_ff[0];
  assign led_b_pin_out = pin_out_ff[1];
  assign led_a_pin_oe = pin_oe_ff;
  assign led_b_pin_oe = pin_oe_ff;

  // ****************************************************
  // checks
  // ****************************************************
  logic run;
  assign run = (state_ff == pld_pkg::PLD_RUN);

  sequence s_sense_end;
    sense_done;
  endsequence

  sequence s_driving;
    ##2 (led_a_pin_oe && led_b_pin_oe);
  endsequence

  property p_drive_after_sense;
    @(posedge clock) disable iff (rst)
    s_sense_end |-> s_driving;
  endproperty
  a_drive_after_sense: assert property (p_drive_after_sense) else $error("pins not driven");

  property p_pol_hold;
    @(posedge clock) disable iff (rst)
    (run && $past(run)) |-> ($stable(sink_a_ff) && $stable(sink_b_ff) && $stable(dup_def_ff));
  endproperty
  a_pol_hold: assert property (p_pol_hold) else $error("polarity changed in run");

  property p_dup_half;
    @(posedge clock) disable iff (rst)
    (sense_done && !led_b_pin_in) |=> !duplex_default_bit;
  endproperty
  a_dup_half: assert property (p_dup_half) else $error("half duplex default wrong");

  property p_dup_full;
    @(posedge clock) disable iff (rst)
    (sense_done && led_b_pin_in) |=> duplex_default_bit;
  endproperty
  a_dup_full: assert property (p_dup_full) else $error("full duplex default wrong");

  property p_on;
    @(posedge clock) disable iff (rst)
    (run && code[0] == pld_pkg::PLD_F_ON) |=> led_a_pin_out == ~sink_a_ff;
  endproperty
  a_on: assert property (p_on) else $error("led a not lit");

  property p_off;
    @(posedge clock) disable iff (rst)
    (run && code[1] == pld_pkg::PLD_F_OFF) |=> led_b_pin_out == sink_b_ff;
  endproperty
  a_off: assert property (p_off) else $error("led b not dark");

  property p_link;
    @(posedge clock) disable iff (rst)
    (run && code[0] == pld_pkg::PLD_F_LINK) |=> led_a_pin_out == ($past(link_up) ^ sink_a_ff);
  endproperty
  a_link: assert property (p_link) else $error("link level not shown");

  property p_combined_stretch;
    @(posedge clock) disable iff (rst)
    (run && code[1] == pld_pkg::PLD_F_DUP_COL && !stretch_en && col_act) ##1
      (code[1] == pld_pkg::PLD_F_DUP_COL && !col_act) |-> active[1];
  endproperty
  a_combined_stretch: assert property (p_combined_stretch) else $error("combined not stretched");

  property p_tx_plain;
    @(posedge clock) disable iff (rst)
    (run && code[0] == pld_pkg::PLD_F_TX && !stretch_en) |-> active[0] == tx_act;
  endproperty
  a_tx_plain: assert property (p_tx_plain) else $error("tx shown wrongly");

endmodule : pld_top

//--- shared/pld_pkg.sv
// Purpose: constants and types for the phy led driver
// Assumes: 100 MHz main clock
// Notes: cycle counts derive from the stretch and blink times
// How it works
// - at reset sense each led pin's wiring, then drive selected default state
// - sensed polarity holds until the next system reset
// - second led sourcing current at reset clears the duplex default bit
// - second led sinking current at reset sets the duplex default bit
// - with no second led the duplex default bit is indeterminate
// - first field bits 11:8; on, off, fast and slow blink codes
// - codes 0001, 0010, 0011, 0111 show stretchable tx, rx, collision, tx or rx
// - code 0100 shows link level, 0101 shows duplex level
// - codes 1100, 1101, 1110 combine a level with always stretched activity
// - second field bits 7:4 decodes the same codes
// - bits 3:2 select normal, medium or long stretch; 11 reserved
// - stretch enable set lengthens stretchable events by the selected time
// - stretch enable clear shows stretchable events only while they occur
// - stretch times 40, 70 and 140 ms
// - led control reached only through the management register port
package pld_pkg;

  // ****************************************************
  // clock and times
  // ****************************************************
  localparam int unsigned CLK_KHZ = 100000;
  localparam int unsigned STRETCH_NORMAL_MS = 40;
  localparam int unsigned STRETCH_MEDIUM_MS = 70;
  localparam int unsigned STRETCH_LONG_MS = 140;
  localparam int unsigned STRETCH_NORMAL_CYC = STRETCH_NORMAL_MS * CLK_KHZ;
  localparam int unsigned STRETCH_MEDIUM_CYC = STRETCH_MEDIUM_MS * CLK_KHZ;
  localparam int unsigned STRETCH_LONG_CYC = STRETCH_LONG_MS * CLK_KHZ;
  localparam int unsigned BLINK_FAST_HALF_MS = 50;
  localparam int unsigned BLINK_SLOW_HALF_MS = 200;
  localparam int unsigned BLINK_FAST_HALF_CYC = BLINK_FAST_HALF_MS * CLK_KHZ;
  localparam int unsigned BLINK_SLOW_HALF_CYC = BLINK_SLOW_HALF_MS * CLK_KHZ;
  // settle time for the floating pin before it is sampled
  localparam logic [2:0] SENSE_CYC = 3'h4;

  // ****************************************************
  // led control register layout
  // ****************************************************
  localparam int unsigned LED_A_LSB = 8;
  localparam int unsigned LED_B_LSB = 4;
  localparam int unsigned LEN_LSB = 2;
  localparam int unsigned STRETCH_EN_BIT = 1;
  localparam logic [15:0] LED_CONTROL_RST = 16'h3422;

  typedef enum logic [3:0] {
    PLD_F_RSV0 = 4'h0,
    PLD_F_TX = 4'h1,
    PLD_F_RX = 4'h2,
    PLD_F_COL = 4'h3,
    PLD_F_LINK = 4'h4,
    PLD_F_DUP = 4'h5,
    PLD_F_RSV6 = 4'h6,
    PLD_F_TXRX = 4'h7,
    PLD_F_ON = 4'h8,
    PLD_F_OFF = 4'h9,
    PLD_F_FAST = 4'ha,
    PLD_F_SLOW = 4'hb,
    PLD_F_LINK_RX = 4'hc,
    PLD_F_LINK_TXRX = 4'hd,
    PLD_F_DUP_COL = 4'he,
    PLD_F_RSVF = 4'hf
  } pld_func_t;

  typedef enum logic [1:0] {
    PLD_LEN_NORMAL = 2'h0,
    PLD_LEN_MEDIUM = 2'h1,
    PLD_LEN_LONG = 2'h2,
    PLD_LEN_RSV = 2'h3
  } pld_len_t;

  typedef enum logic [1:0] {
    PLD_SENSE = 2'b01,
    PLD_RUN = 2'b10
  } pld_state_t;

endpackage : pld_pkg

//--- shared/pld_str_if.sv
// Purpose: link between led decode and one event stretcher
// Assumes: single clock domain
// Notes: active is combinational
`timescale 1ns/100ps
interface pld_str_if;
  logic evt;
  logic force_str;
  logic en;
  pld_pkg::pld_len_t sel;
  logic active;
  modport ctl (output evt, output force_str, output en, output sel, input active);
  modport str (input evt, input force_str, input en, input sel, output active);
endinterface : pld_str_if

//--- sim/pld_led_model.sv
// Purpose: one led on one device pin, wired to source or to sink
// Assumes: a sourcing led goes to ground, a sinking led goes to supply
// Notes: a detached pin shows a level that changes every cycle
`timescale 1ns/100ps
module pld_led_model (
  input wire logic clock,
  input wire logic sink,
  input wire logic attached,
  input wire logic pin_out,
  input wire logic pin_oe,
  output logic pin_in,
  output logic lit
);
  logic float_ff;

  // ****************************************************
  // pin level and light
  // ****************************************************
  // a floating pin must not hold a stale level the device could sense
  always @(posedge clock)
  begin
    float_ff <= (float_ff === 1'b1) ? 1'b0 : 1'b1;
  end

  // an undriven pin is pulled toward the far end of the led
  assign pin_in = pin_oe ? pin_out : (attached ? sink : float_ff);
  assign lit = attached & pin_oe & (pin_out ^ sink);
endmodule : pld_led_model

//--- sim/tb_top.sv
// Purpose: self-checking bench for the phy led driver
// Assumes: shortened stretch and blink counts
// Notes: durations allow a few cycles of pipeline slack
`timescale 1ns/100ps
`define CHK(nm, exp, got) begin comparisons++; if ((got) !== (exp)) begin n_fail++; \
  $display("CHECK FAILED %s expected %h seen %h", nm, exp, got); end end
module tb_top;
  localparam int NORM = 20;
  localparam int MED = 35;
  localparam int LONG = 70;
  localparam logic [3:0] FCODE [7] = '{4'h8, 4'h9, 4'h4, 4'h5, 4'h0, 4'h6, 4'hf};
  localparam logic [3:0] SCODE [4] = '{4'h1, 4'h2, 4'h3, 4'h7};
  localparam logic [2:0] SACT [4] = '{3'h1, 3'h2, 3'h4, 3'h2};
  localparam logic [3:0] CCODE [3] = '{4'hc, 4'hd, 4'he};
  localparam logic [2:0] CACT [3] = '{3'h2, 3'h1, 3'h4};
  localparam int LENS [4] = '{NORM, MED, LONG, NORM};
  logic clock, rst, reg_wr, tx_act, rx_act, col_act, link_up, duplex_full;
  logic [15:0] reg_wdata, reg_rdata;
  logic duplex_default_bit, sink_a, sink_b;
  logic a_in, a_out, a_oe, b_in, b_out, b_oe, a_lit, b_lit;
  int n_fail, comparisons;

  // ****************************************************
  // clock, design and leds
  // ****************************************************
  initial
  begin
    clock = 1'b0;
    forever #5 clock = ~clock;
  end

  pld_top #(.NORM_CYC(NORM), .MED_CYC(MED), .LONG_CYC(LONG), .FAST_HALF_CYC(4),
    .SLOW_HALF_CYC(16)) dut (.clock(clock), .rst(rst), .reg_wr(reg_wr),
    .reg_wdata(reg_wdata), .reg_rdata(reg_rdata), .duplex_default_bit(duplex_default_bit),
    .tx_act(tx_act), .rx_act(rx_act), .col_act(col_act), .link_up(link_up),
    .duplex_full(duplex_full), .led_a_pin_in(a_in), .led_a_pin_out(a_out),
    .led_a_pin_oe(a_oe), .led_b_pin_in(b_in), .led_b_pin_out(b_out), .led_b_pin_oe(b_oe));
  pld_led_model led_a (.clock(clock), .sink(sink_a), .attached(1'b1), .pin_out(a_out),
    .pin_oe(a_oe), .pin_in(a_in), .lit(a_lit));
  pld_led_model led_b (.clock(clock), .sink(sink_b), .attached(1'b1), .pin_out(b_out),
    .pin_oe(b_oe), .pin_in(b_in), .lit(b_lit));

  // ****************************************************
  // tasks
  // ****************************************************
  task automatic finish_test();
    $display("comparisons %0d mismatches %0d", comparisons, n_fail);
    if (n_fail == 0 && comparisons > 0)
      $display("Finished cleanly");
    else
      $display("Finished with errors");
    $finish;
  endtask : finish_test

  task automatic rng(input string nm, input int d, input int lo, input int hi);
    `CHK(nm, lo, ((d >= lo && d <= hi) ? lo : d))
  endtask : rng

  task automatic do_reset(input logic sa, input logic sb);
    @(posedge clock);
    sink_a <= sa;
    sink_b <= sb;
    rst <= 1'b1;
    repeat (3) @(posedge clock);
    rst <= 1'b0;
    repeat (2) @(posedge clock);
    #1;
    `CHK("oe while sensing", 1'b0, a_oe);
    repeat (8) @(posedge clock);
    #1;
  endtask : do_reset

  task automatic wr(input logic [3:0] fa, input logic [3:0] fb, input logic [1:0] len,
    input logic en);
    logic [15:0] v;
    v = {4'h3, fa, fb, len, en, 1'b0};
    @(posedge clock);
    reg_wr <= 1'b1;
    reg_wdata <= v;
    @(posedge clock);
    reg_wr <= 1'b0;
    @(posedge clock);
    #1;
    `CHK("readback", v, reg_rdata);
    repeat (2) @(posedge clock);
    #1;
  endtask : wr

  // counts cycles the led differs from its resting level after a one-cycle event
  task automatic run(input logic [2:0] act, input logic sel_b, input logic base,
    output int d);
    @(posedge clock);
    {col_act, rx_act, tx_act} <= act;
    @(posedge clock);
    {col_act, rx_act, tx_act} <= 3'h0;
    d = 0;
    repeat (200)
    begin
      #1;
      if ((sel_b ? b_lit : a_lit) !== base)
        d++;
      @(posedge clock);
    end
  endtask : run

  task automatic toggles(output int t);
    logic last;
    t = 0;
    last = a_lit;
    repeat (64)
    begin
      @(posedge clock);
      #1;
      if (a_lit !== last)
        t++;
      last = a_lit;
    end
  endtask : toggles

  // ****************************************************
  // tests
  // ****************************************************
  initial
  begin
    int d;
    logic e;
    logic [3:0] c;
    rst = 1'b1;
    reg_wr = 1'b0;
    reg_wdata = 16'h0000;
    {col_act, rx_act, tx_act} = 3'h0;
    link_up = 1'b1;
    duplex_full = 1'b0;
    sink_a = 1'b0;
    sink_b = 1'b1;
    n_fail = 0;
    comparisons = 0;
    do_reset(1'b0, 1'b1);
    `CHK("reset value", 16'h3422, reg_rdata);
    `CHK("duplex from sinking b", 1'b1, duplex_default_bit);
    `CHK("led a default", 1'b1, a_lit);
    `CHK("led b default", 1'b0, b_lit);
    run(3'h2, 1'b1, 1'b0, d);
    rng("default rx stretch", d, NORM, NORM + 4);
    @(posedge clock);
    sink_a <= 1'b1;
    sink_b <= 1'b0;
    repeat (4) @(posedge clock);
    #1;
    `CHK("pin after rewire", 1'b1, a_out);
    `CHK("duplex after rewire", 1'b1, duplex_default_bit);
    do_reset(1'b1, 1'b0);
    `CHK("duplex from sourcing b", 1'b0, duplex_default_bit);
    `CHK("sinking pin drive", 1'b0, a_out);
    `CHK("sinking led lit", 1'b1, a_lit);
    for (int p = 0; p < 2; p++)
    begin
      @(posedge clock);
      link_up <= (p == 0);
      duplex_full <= (p == 1);
      for (int i = 0; i < 7; i++)
      begin
        c = FCODE[i];
        e = (c == 4'h8) || (c == 4'h4 && p == 0) || (c == 4'h5 && p == 1);
        wr(c, 4'h9, 2'h0, 1'b0);
        `CHK("led a function", e, a_lit);
        if (c != 4'hf)
        begin
          wr(4'h9, c, 2'h0, 1'b0);
          `CHK("led b function", e, b_lit);
        end
      end
    end
    @(posedge clock);
    link_up <= 1'b0;
    duplex_full <= 1'b0;
    for (int i = 0; i < 4; i++)
    begin
      wr(SCODE[i], 4'h9, 2'h0, 1'b0);
      run(SACT[i], 1'b0, 1'b0, d);
      rng("unstretched event", d, 1, 3);
      wr(SCODE[i], 4'h9, 2'h0, 1'b1);
      run(SACT[i], 1'b0, 1'b0, d);
      rng("stretched event", d, NORM, NORM + 4);
    end
    for (int i = 0; i < 4; i++)
    begin
      wr(4'h1, 4'h9, i[1:0], 1'b1);
      run(3'h1, 1'b0, 1'b0, d);
      rng("stretch length", d, LENS[i], LENS[i] + 4);
    end
    @(posedge clock);
    link_up <= 1'b1;
    duplex_full <= 1'b1;
    // led b carries the same combined code so its forced stretch is exercised too
    for (int i = 0; i < 3; i++)
    begin
      wr(CCODE[i], CCODE[i], 2'h0, 1'b0);
      run(CACT[i], 1'b0, 1'b1, d);
      rng("combined mode", d, NORM, NORM + 4);
    end
    wr(4'ha, 4'h9, 2'h0, 1'b0);
    toggles(d);
    rng("fast blink", d, 12, 17);
    wr(4'hb, 4'h9, 2'h0, 1'b0);
    toggles(d);
    rng("slow blink", d, 3, 5);
    finish_test();
  end

  // a hang counts as a mismatch and ends the run the same way
  initial
  begin
    #500000;
    n_fail++;
    finish_test();
  end
endmodule : tb_top
